// ===== shared/serial_ch0_pkg.sv
// shared constants for the serial channel 0 control and status block
package serial_ch0_pkg;
  // register addresses
  localparam logic [15:0] MODE_ADDR = 16'hFF60;
  localparam logic [15:0] SHIFT_ADDR = 16'hFF62;
  localparam logic [15:0] TIMING_ADDR = 16'hFF63;
  // reset values
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [7:0] TIMING_RESET = 8'h00;
  localparam logic [7:0] SHIFT_RESET = 8'h00;
  // mode register fields
  localparam int CHANNEL_ENABLE_BIT = 7;
  localparam int WAKEUP_SELECT_BIT = 5;
  localparam int MODE_SEL_HI = 4;
  localparam int MODE_SEL_LO = 2;
  localparam logic [7:0] MODE_WRITABLE = 8'hBF;
  // interrupt timing register fields
  localparam int CLOCK_LEVEL_BIT = 6;
  localparam int CAUSE_SELECT_BIT = 5;
  localparam int ADDRESS_MASK_BIT = 4;
  localparam logic [7:0] TIMING_WRITABLE = 8'h30;
  // address compare mask when only bits 1 to 7 take part
  localparam logic [7:0] ADDR_MASK_UPPER = 8'hFE;
  localparam logic [7:0] ADDR_MASK_ALL = 8'hFF;
  // operating modes of the channel
  typedef enum logic [1:0] {
    MODE_STOP,
    MODE_THREE_WIRE,
    MODE_TWO_LINE_BUS,
    MODE_TWO_WIRE
  } op_mode_t;
endpackage

// ===== design/level_sync.sv
// two-stage synchroniser for a level from outside the clock domain
`timescale 1ns/1ns
module level_sync (
  input wire logic clk_in,    // system clock
  input wire logic rst_n_in,  // synchronised reset, active low
  input wire logic level_in,  // asynchronous level
  output logic level_out      // synchronised level
);
  typedef struct packed {
    logic first;
    logic second;
  } sync_state_t;

  sync_state_t state;
  sync_state_t next_state;

  // first stage feeds only the second stage
  always_comb begin
    next_state.first = level_in;
    next_state.second = state.first;
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state <= '0;
    end else begin
      state <= next_state;
    end
  end

  assign level_out = state.second;
endmodule

// ===== design/slave_addr_compare.sv
// slave address comparison with optional exclusion of bit 0
`timescale 1ns/1ns
module slave_addr_compare (
  input wire logic [7:0] rx_addr_in,     // received address
  input wire logic [7:0] slave_addr_in,  // slave address register value
  input wire logic mask_bit0_in,         // 1 ignores bit 0
  output logic match_out                 // addresses agree on compared bits
);
  logic [7:0] mask;

  // choose which bits take part
  always_comb begin
    mask = mask_bit0_in ? serial_ch0_pkg::ADDR_MASK_UPPER : serial_ch0_pkg::ADDR_MASK_ALL;
    match_out = ((rx_addr_in ^ slave_addr_in) & mask) == 8'h00;
  end
endmodule

// ===== design/serial_ch0_ctrl.sv
// control and status registers of serial channel 0
//
// Notes on behaviour
// - reset clears interrupt timing register
// - bit 6 reads clock pin level only
// - channel disabled forces clock level zero
// - cause select adds bus release interrupt
// - mask select drops address bit 0
// - registers take bit and byte writes
// - four modes: stop, three-wire, bus, two-wire
// - stop mode: no transfer, no clock
// - stop mode: shift register plain storage
// - stop mode: pins become ordinary ports
// - mode bit 7 enables the channel
// - reset clears mode register, stop mode
`timescale 1ns/1ns
module serial_ch0_ctrl (
  input wire logic mclk_in,               // system clock, 25 MHz
  input wire logic rst_n_in,              // asynchronous reset, active low
  input wire logic [15:0] addr_in,        // cpu memory address
  input wire logic wr_en_in,              // write strobe
  input wire logic bit_wr_in,             // 1: single-bit write, 0: byte write
  input wire logic [2:0] bit_sel_in,      // bit number for single-bit write
  input wire logic [7:0] wdata_in,        // write data, bit value in bit 0 for bit writes
  input wire logic rd_en_in,              // read strobe
  output logic [7:0] rdata_out,           // read data, one cycle after the strobe
  input wire logic serial_clock_pin_in,   // serial clock pin level
  input wire logic transfer_done_in,      // end-of-transfer pulse from the engine
  input wire logic bus_release_in,        // bus release detected pulse
  input wire logic shift_en_in,           // engine shifts the shift register
  input wire logic serial_data_in,        // bit shifted in by the engine
  input wire logic [7:0] rx_addr_in,      // address received on the bus
  input wire logic [7:0] slave_addr_in,   // slave address register value
  output logic address_match_out,         // slave address matched
  output logic channel_interrupt_out,     // interrupt request pulse
  output logic transfer_irq_flag_out,     // sticky request flag
  output logic [1:0] op_mode_out,         // current operating mode
  output logic channel_active_out,        // channel owns its pins
  output logic port_release_out,          // pins act as ordinary ports
  output logic sck_rise_out,              // serial clock rising edge seen
  output logic sck_fall_out,              // serial clock falling edge seen
  output logic [7:0] shift_data_out       // shift register contents
);
  typedef struct packed {
    logic rst_a;
    logic rst_b;
  } rst_state_t;

  typedef struct packed {
    logic [7:0] serial_mode_reg;
    logic [7:0] interrupt_timing_reg;
    logic [7:0] serial_shift_reg;
    logic [7:0] rdata;
    logic irq_pulse;
    logic irq_flag;
    logic sck_prev;
    logic sck_rise;
    logic sck_fall;
  } ctrl_state_t;

  rst_state_t rst_state;
  rst_state_t next_rst_state;
  ctrl_state_t state;
  ctrl_state_t next_state;
  logic rst_n;
  logic sck_level;
  logic enabled;
  logic irq_event;
  logic addr_match;
  logic [1:0] mode_sel;
  logic [7:0] timing_view;
  serial_ch0_pkg::op_mode_t op_mode;

  ////////////////////////////////////////////////////////////////////////////
  // reset release through two flops; assertion stays asynchronous
  always_comb begin
    next_rst_state.rst_a = 1'b1;
    next_rst_state.rst_b = rst_state.rst_a;
  end

  always_ff @(posedge mclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      rst_state <= '0;
    end else begin
      rst_state <= next_rst_state;
    end
  end

  assign rst_n = rst_state.rst_b;

  ////////////////////////////////////////////////////////////////////////////
  // pin level brought into the system clock domain
  level_sync u_sck_sync (
    .clk_in(mclk_in),
    .rst_n_in(rst_n),
    .level_in(serial_clock_pin_in),
    .level_out(sck_level)
  );

  slave_addr_compare u_addr_cmp (
    .rx_addr_in(rx_addr_in),
    .slave_addr_in(slave_addr_in),
    .mask_bit0_in(state.interrupt_timing_reg[serial_ch0_pkg::ADDRESS_MASK_BIT]),
    .match_out(addr_match)
  );

  ////////////////////////////////////////////////////////////////////////////
  // mode decode: bit 4 low is three-wire, 10 bus, 11 two-wire
  assign enabled = state.serial_mode_reg[serial_ch0_pkg::CHANNEL_ENABLE_BIT];
  assign mode_sel = state.serial_mode_reg[serial_ch0_pkg::MODE_SEL_HI -: 2];

  always_comb begin
    if (!enabled) begin
      op_mode = serial_ch0_pkg::MODE_STOP;
    end else if (!mode_sel[1]) begin
      op_mode = serial_ch0_pkg::MODE_THREE_WIRE;
    end else if (!mode_sel[0]) begin
      op_mode = serial_ch0_pkg::MODE_TWO_LINE_BUS;
    end else begin
      op_mode = serial_ch0_pkg::MODE_TWO_WIRE;
    end
  end

  // interrupt cause: end of transfer, plus bus release when selected
  always_comb begin
    irq_event = enabled && (transfer_done_in ||
      (bus_release_in && state.interrupt_timing_reg[serial_ch0_pkg::CAUSE_SELECT_BIT]));
  end

  // level flag blanked as soon as the channel stops, not one cycle later
  always_comb begin
    timing_view = state.interrupt_timing_reg;
    timing_view[serial_ch0_pkg::CLOCK_LEVEL_BIT] = enabled &&
      state.interrupt_timing_reg[serial_ch0_pkg::CLOCK_LEVEL_BIT];
  end

  ////////////////////////////////////////////////////////////////////////////
  // next-state of all registers
  always_comb begin
    next_state = state;
    next_state.irq_pulse = irq_event;
    next_state.sck_prev = sck_level;
    // edges only reported while the channel runs
    next_state.sck_rise = enabled && sck_level && !state.sck_prev;
    next_state.sck_fall = enabled && !sck_level && state.sck_prev;
    // engine shifting is locked out in stop mode
    if (enabled && shift_en_in) begin
      next_state.serial_shift_reg = {state.serial_shift_reg[6:0], serial_data_in};
    end
    // cpu writes; bit writes touch one writable bit, byte writes all writable bits
    if (wr_en_in) begin
      unique case (addr_in)
        serial_ch0_pkg::MODE_ADDR: begin
          if (bit_wr_in) begin
            if (serial_ch0_pkg::MODE_WRITABLE[bit_sel_in]) begin
              next_state.serial_mode_reg[bit_sel_in] = wdata_in[0];
            end
          end else begin
            next_state.serial_mode_reg = wdata_in & serial_ch0_pkg::MODE_WRITABLE;
          end
        end
        serial_ch0_pkg::TIMING_ADDR: begin
          // clock level bit and reserved bits ignore writes
          if (bit_wr_in) begin
            if (serial_ch0_pkg::TIMING_WRITABLE[bit_sel_in]) begin
              next_state.interrupt_timing_reg[bit_sel_in] = wdata_in[0];
            end
          end else begin
            next_state.interrupt_timing_reg = wdata_in & serial_ch0_pkg::TIMING_WRITABLE;
          end
        end
        serial_ch0_pkg::SHIFT_ADDR: begin
          // cpu byte write wins over a simultaneous engine shift; a bit write lands on the shifted value
          if (bit_wr_in) begin
            next_state.serial_shift_reg[bit_sel_in] = wdata_in[0];
          end else begin
            next_state.serial_shift_reg = wdata_in;
          end
        end
        default: begin
        end
      endcase
    end
    // clock level is a live image, forced low while disabled
    next_state.interrupt_timing_reg[serial_ch0_pkg::CLOCK_LEVEL_BIT] = enabled && sck_level;
    // request flag: hardware set wins over cpu clear via timing read
    if (irq_event) begin
      next_state.irq_flag = 1'b1;
    end else if (rd_en_in && addr_in == serial_ch0_pkg::TIMING_ADDR) begin
      next_state.irq_flag = 1'b0;
    end
    // registered read data; unmapped addresses read zero
    if (rd_en_in) begin
      unique case (addr_in)
        serial_ch0_pkg::MODE_ADDR: next_state.rdata = state.serial_mode_reg;
        serial_ch0_pkg::TIMING_ADDR: next_state.rdata = timing_view;
        serial_ch0_pkg::SHIFT_ADDR: next_state.rdata = state.serial_shift_reg;
        default: next_state.rdata = 8'h00;
      endcase
    end
  end

  // reset places the channel in stop mode with cleared registers
  always_ff @(posedge mclk_in or negedge rst_n) begin
    if (!rst_n) begin
      state <= '0;
      state.serial_mode_reg <= serial_ch0_pkg::MODE_RESET;
      state.interrupt_timing_reg <= serial_ch0_pkg::TIMING_RESET;
      state.serial_shift_reg <= serial_ch0_pkg::SHIFT_RESET;
    end else begin
      state <= next_state;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // outputs
  assign rdata_out = state.rdata;
  assign address_match_out = enabled && addr_match;
  assign channel_interrupt_out = state.irq_pulse;
  assign transfer_irq_flag_out = state.irq_flag;
  assign op_mode_out = op_mode;
  assign channel_active_out = enabled;
  assign port_release_out = !enabled;
  assign sck_rise_out = state.sck_rise;
  assign sck_fall_out = state.sck_fall;
  assign shift_data_out = state.serial_shift_reg;
endmodule

// ===== tb/serial_ch0_chk.sv
// assertions on the serial channel 0 control ports
`timescale 1ns/1ns
module serial_ch0_chk (
  input wire logic mclk_in, // clock
  input wire logic rst_n_in, // reset
  input wire logic [15:0] addr_in, // address
  input wire logic wr_en_in, // write
  input wire logic rd_en_in, // read
  input wire logic [7:0] rdata_out, // read data
  input wire logic transfer_done_in, // done
  input wire logic bus_release_in, // release
  input wire logic channel_interrupt_out, // irq pulse
  input wire logic transfer_irq_flag_out, // irq flag
  input wire logic [1:0] op_mode_out, // mode
  input wire logic channel_active_out, // enabled
  input wire logic port_release_out, // ports free
  input wire logic sck_rise_out, // rise
  input wire logic sck_fall_out, // fall
  input wire logic [7:0] shift_data_out // shift reg
);
  // one domain, so one clock and reset for all
  default clocking @(posedge mclk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////
  property p_release; port_release_out == !channel_active_out; endproperty
  a_release: assert property (p_release)
    else $error("port release wrong");
  property p_stop; !channel_active_out |-> op_mode_out == 2'h0; endproperty
  a_stop: assert property (p_stop)
    else $error("mode not stop");
  property p_quiet; !channel_active_out && !$past(channel_active_out) |-> !sck_rise_out && !sck_fall_out;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("clock edge in stop");
  property p_irq; transfer_done_in && channel_active_out |=> channel_interrupt_out && transfer_irq_flag_out;
  endproperty
  a_irq: assert property (p_irq)
    else $error("no irq after done");
  property p_cause; channel_interrupt_out |-> $past(transfer_done_in) || $past(bus_release_in); endproperty
  a_cause: assert property (p_cause)
    else $error("irq without cause");
  property p_flag; channel_interrupt_out |-> transfer_irq_flag_out; endproperty
  a_flag: assert property (p_flag)
    else $error("flag missing");
  property p_hold; !$past(channel_active_out) && !$past(wr_en_in) |-> $stable(shift_data_out); endproperty
  a_hold: assert property (p_hold)
    else $error("shift moved in stop");
  property p_fixed; rd_en_in && addr_in == serial_ch0_pkg::TIMING_ADDR && !channel_active_out
    |=> rdata_out[7:6] == 2'h0 && rdata_out[3:0] == 4'h0; endproperty
  a_fixed: assert property (p_fixed)
    else $error("timing read bits wrong");
endmodule

// ===== tb/sck_peer.sv
// far-side peer that drives the serial clock pin
`timescale 1ns/1ns
module sck_peer (
  input wire logic frame_in, // peer sends a burst
  input wire logic hold_low_in, // peer holds line low
  output logic sck_out // serial clock pin
);
  logic run = 1'b0;
  // 320 ns clock only in frames; offset so edges never meet mclk
  initial begin
    #7;
    forever #160 run = frame_in ? !run : 1'b0;
  end
  // idle level is high, as with a pull-up
  assign sck_out = hold_low_in ? 1'b0 : !run;
endmodule

// ===== tb/tb_top.sv
// self-checking bench for serial channel 0 control
`timescale 1ns/1ns
module tb_top;
  logic mclk_in = 1'b0, rst_n_in = 1'b0, wr_en_in = 1'b0, bit_wr_in = 1'b0, rd_en_in = 1'b0;
  logic transfer_done_in = 1'b0, bus_release_in = 1'b0, shift_en_in = 1'b0, serial_data_in = 1'b0;
  logic frame = 1'b0, hold_low = 1'b0, serial_clock_pin_in, address_match_out, channel_interrupt_out;
  logic transfer_irq_flag_out, channel_active_out, port_release_out, sck_rise_out, sck_fall_out;
  logic [2:0] bit_sel_in = 3'h0;
  logic [15:0] addr_in = 16'h0000;
  logic [7:0] wdata_in = 8'h00, rx_addr_in = 8'h5A, slave_addr_in = 8'h5B, rdata_out, shift_data_out, v;
  logic [1:0] op_mode_out;
  int miscompares = 0, total_checks = 0, rises = 0, falls = 0;
  serial_ch0_ctrl dut (
    .mclk_in(mclk_in),
    .rst_n_in(rst_n_in),
    .addr_in(addr_in),
    .wr_en_in(wr_en_in),
    .bit_wr_in(bit_wr_in),
    .bit_sel_in(bit_sel_in),
    .wdata_in(wdata_in),
    .rd_en_in(rd_en_in),
    .rdata_out(rdata_out),
    .serial_clock_pin_in(serial_clock_pin_in),
    .transfer_done_in(transfer_done_in),
    .bus_release_in(bus_release_in),
    .shift_en_in(shift_en_in),
    .serial_data_in(serial_data_in),
    .rx_addr_in(rx_addr_in),
    .slave_addr_in(slave_addr_in),
    .address_match_out(address_match_out),
    .channel_interrupt_out(channel_interrupt_out),
    .transfer_irq_flag_out(transfer_irq_flag_out),
    .op_mode_out(op_mode_out),
    .channel_active_out(channel_active_out),
    .port_release_out(port_release_out),
    .sck_rise_out(sck_rise_out),
    .sck_fall_out(sck_fall_out),
    .shift_data_out(shift_data_out)
  );
  sck_peer peer (.frame_in(frame), .hold_low_in(hold_low), .sck_out(serial_clock_pin_in));
  always #20 mclk_in = !mclk_in;
  // free-running edge counts; scenarios take snapshots so only this process writes them
  always @(posedge mclk_in) begin
    rises += int'(sck_rise_out);
    falls += int'(sck_fall_out);
  end
  ////////////////////////////////////////////////////////////
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    total_checks++;
    if (g !== e) begin
      miscompares++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask
  // requests change 1 ns after an edge and hold over the taking edge
  // an idle edge first, so a strobe is never lowered and raised in one step
  task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic b = 1'b0, input logic [2:0] s = 3'h0);
    @(posedge mclk_in) #1;
    addr_in = a; wdata_in = d; bit_wr_in = b; bit_sel_in = s; wr_en_in = 1'b1;
    @(posedge mclk_in) #1 wr_en_in = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a);
    addr_in = a; rd_en_in = 1'b1;
    @(posedge mclk_in) #1 rd_en_in = 1'b0;
    @(posedge mclk_in) #1 v = rdata_out;
  endtask
  task automatic pulse(input logic rel);
    @(posedge mclk_in) #1;
    transfer_done_in = !rel; bus_release_in = rel;
    @(posedge mclk_in) #1 {transfer_done_in, bus_release_in} = 2'h0;
  endtask
  task automatic final_report;
    $display("checks %0d miscompares %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  task automatic t_reset;
    rd(serial_ch0_pkg::MODE_ADDR); chk("mode", 8'h00, v);
    rd(serial_ch0_pkg::TIMING_ADDR); chk("timing", 8'h00, v);
    chk("release", 8'h01, {7'h00, port_release_out});
  endtask
  task automatic t_regs;
    logic [7:0] mc [3] = '{8'h80, 8'h90, 8'h9C};
    wr(serial_ch0_pkg::TIMING_ADDR, 8'hF0); rd(serial_ch0_pkg::TIMING_ADDR); chk("tim", 8'h30, v);
    wr(serial_ch0_pkg::TIMING_ADDR, 8'h00, 1'b1, 3'h5); rd(serial_ch0_pkg::TIMING_ADDR); chk("bit", 8'h10, v);
    for (int i = 0; i < 3; i++) begin
      wr(serial_ch0_pkg::MODE_ADDR, mc[i]); chk("opmode", 8'(i + 5), {5'h00, channel_active_out, op_mode_out});
    end
    wr(serial_ch0_pkg::MODE_ADDR, 8'h00, 1'b1, 3'h7);
    chk("stop", 8'h01, {6'h00, channel_active_out, port_release_out});
    rd(serial_ch0_pkg::MODE_ADDR); chk("mode", 8'h1C, v);
  endtask
  task automatic t_clock;
    int r0, f0;
    wr(serial_ch0_pkg::MODE_ADDR, 8'h80); repeat (4) @(posedge mclk_in);
    #1 rd(serial_ch0_pkg::TIMING_ADDR); chk("high", 8'h50, v);
    // pin pulled low: two sync stages plus the register keep the old level for two reads
    hold_low = 1'b1; rd(serial_ch0_pkg::TIMING_ADDR); chk("sync1", 8'h50, v);
    rd(serial_ch0_pkg::TIMING_ADDR); chk("sync2", 8'h50, v);
    rd(serial_ch0_pkg::TIMING_ADDR); chk("low", 8'h10, v);
    hold_low = 1'b0; r0 = rises; f0 = falls; frame = 1'b1; repeat (64) @(posedge mclk_in);
    #1 frame = 1'b0; chk("rises", 8'h01, {7'h00, rises > r0});
    chk("falls", 8'h01, {7'h00, falls > f0});
    // let edges launched before the stop drain out of the counters
    wr(serial_ch0_pkg::MODE_ADDR, 8'h00); repeat (4) @(posedge mclk_in);
    #1 r0 = rises; f0 = falls; frame = 1'b1; repeat (32) @(posedge mclk_in);
    #1 frame = 1'b0; chk("stopped", 8'h00, 8'(rises - r0 + falls - f0));
    // pin back at its idle high level, flag must still read low
    repeat (8) @(posedge mclk_in);
    #1 rd(serial_ch0_pkg::TIMING_ADDR); chk("forced", 8'h10, v);
  endtask
  task automatic t_irq;
    // wake-up stays off, so the cause select may be set further down
    wr(serial_ch0_pkg::MODE_ADDR, 8'h80);
    wr(serial_ch0_pkg::TIMING_ADDR, 8'h00);
    pulse(1'b1); chk("no irq", 8'h00, {6'h00, channel_interrupt_out, transfer_irq_flag_out});
    pulse(1'b0); chk("irq", 8'h03, {6'h00, channel_interrupt_out, transfer_irq_flag_out});
    chk("match", 8'h00, {7'h00, address_match_out});
    wr(serial_ch0_pkg::TIMING_ADDR, 8'h30); chk("masked", 8'h01, {7'h00, address_match_out});
    rd(serial_ch0_pkg::TIMING_ADDR); chk("cleared", 8'h00, {7'h00, transfer_irq_flag_out});
    pulse(1'b1); chk("rel irq", 8'h03, {6'h00, channel_interrupt_out, transfer_irq_flag_out});
    shift_en_in = 1'b1; serial_data_in = 1'b1; wr(serial_ch0_pkg::MODE_ADDR, 8'h00);
    wr(serial_ch0_pkg::SHIFT_ADDR, 8'hA5); repeat (2) @(posedge mclk_in);
    #1 chk("plain", 8'hA5, shift_data_out);
    rd(serial_ch0_pkg::SHIFT_ADDR); chk("shift rd", 8'hA5, v);
    shift_en_in = 1'b0;
  endtask
  ////////////////////////////////////////////////////////////
  // reset, then the scenarios in turn
  initial begin
    repeat (4) @(posedge mclk_in);
    #1 rst_n_in = 1'b1;
    repeat (3) @(posedge mclk_in);
    #1 t_reset();
    t_regs();
    t_clock();
    t_irq();
    final_report();
  end
  // watchdog at 5000 cycles, far beyond the fewer than 200 cycles used
  initial begin
    #200000 miscompares++;
    final_report();
  end
endmodule
bind serial_ch0_ctrl serial_ch0_chk chk_i (
  .mclk_in(mclk_in),
  .rst_n_in(rst_n_in),
  .addr_in(addr_in),
  .wr_en_in(wr_en_in),
  .rd_en_in(rd_en_in),
  .rdata_out(rdata_out),
  .transfer_done_in(transfer_done_in),
  .bus_release_in(bus_release_in),
  .channel_interrupt_out(channel_interrupt_out),
  .transfer_irq_flag_out(transfer_irq_flag_out),
  .op_mode_out(op_mode_out),
  .channel_active_out(channel_active_out),
  .port_release_out(port_release_out),
  .sck_rise_out(sck_rise_out),
  .sck_fall_out(sck_fall_out),
  .shift_data_out(shift_data_out)
);
